// [core/cmm_mode_ctl.sv]
// mode registers and control decode for the data cache and miss file
`default_nettype none
module cmm_mode_ctl (
  // clock and resets
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic timeout_reset_in,
  // register port
  input wire logic [9:0] reg_addr_in,
  input wire logic [11:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [11:0] reg_rdata_out,
  // cache access side
  input wire logic cache_tag_match_in,
  input wire logic cache_load_in,
  input wire logic cache_store_in,
  input wire logic cache_fill_in,
  input wire logic cache_int_store_in,
  input wire logic cache_data_parity_in,
  input wire logic cache_tag_perr_in,
  input wire logic cache_data_perr_in,
  output logic cache_hit_out,
  output logic cache_write_en_out,
  output logic cache_data_parity_out,
  output logic cache_perr_report_out,
  // miss file side
  input wire logic load_issue_in,
  input wire logic store_issue_in,
  input wire logic [39:0] load_paddr_in,
  input wire logic load_locked_in,
  input wire logic [2:0] wb_count_in,
  input wire logic read_miss_req_in,
  input wire logic wb_req_in,
  input wire logic other_req_in,
  input wire logic read_outstanding_in,
  input wire logic wb_outstanding_in,
  output logic load_new_nomerge_out,
  output logic store_new_nomerge_out,
  output logic io_load_nomerge_out,
  output logic wb_flush_out,
  output logic read_miss_grant_ok_out,
  output logic wb_grant_ok_out,
  output logic other_grant_ok_out,
  output logic wb_low_prio_req_out
);
  //---------------------------------------------------------------------------
  // registers
  //---------------------------------------------------------------------------
  logic [3:0] cache_mode_reg; // cache mode bits
  logic [3:0] cache_mode_next;
  logic [11:0] miss_mode_reg; // miss mode bits, status positions held zero
  logic [11:0] miss_mode_next;
  logic [11:0] rdata_reg; // read data register
  logic [11:0] rdata_next;
  logic [8:0] wb_timer_reg; // store buffer age timer
  logic [8:0] wb_timer_next;
  cmm_pkg::cmm_lp_state_t lp_state_reg; // low priority arbitration state
  cmm_pkg::cmm_lp_state_t lp_state_next;
  // registered outputs
  logic [7:0] cache_out_reg;
  logic [7:0] cache_out_next;
  logic [7:0] miss_out_reg;
  logic [7:0] miss_out_next;
  //---------------------------------------------------------------------------
  // decode
  //---------------------------------------------------------------------------
  wire sel_cache = (reg_addr_in == cmm_pkg::CMM_IDX_CACHE_MODE);
  wire sel_miss = (reg_addr_in == cmm_pkg::CMM_IDX_MISS_MODE);
  wire wr_cache = reg_wr_in & sel_cache;
  wire wr_miss = reg_wr_in & sel_miss;
  wire [1:0] pend_sync; // synchronised outstanding levels
  wire [2:0] start_cnt;
  wire [2:0] stop_cnt;
  cmm_pkg::cmm_cache_ctl_t cctl;
  cmm_pkg::cmm_miss_ctl_t mctl;
  assign cctl.cache_enable = cache_mode_reg[cmm_pkg::CMM_CM_ENABLE];
  assign cctl.cache_force_hit = cache_mode_reg[cmm_pkg::CMM_CM_FORCE_HIT];
  assign cctl.parity_corrupt_inject = cache_mode_reg[cmm_pkg::CMM_CM_PAR_INJECT];
  assign cctl.parity_report_disable = cache_mode_reg[cmm_pkg::CMM_CM_PAR_RPT_DIS];
  assign mctl.read_miss_merge_disable = miss_mode_reg[cmm_pkg::CMM_MM_RD_NOMERGE];
  assign mctl.store_buffer_flush_always = miss_mode_reg[cmm_pkg::CMM_MM_FLUSH_ALWAYS];
  assign mctl.store_buffer_merge_disable = miss_mode_reg[cmm_pkg::CMM_MM_STORE_BUFFER_MERGE_DISABLE];
  assign mctl.io_load_merge_prevent = miss_mode_reg[cmm_pkg::CMM_MM_IO_NOMERGE];
  assign mctl.store_buffer_timer_disable = miss_mode_reg[cmm_pkg::CMM_MM_TIMER_DIS];
  assign mctl.miss_arbiter_disable = miss_mode_reg[cmm_pkg::CMM_MM_ARB_DIS];
  // status sampling
  cmm_status_sync u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .level_in({wb_outstanding_in, read_outstanding_in}),
    .level_out(pend_sync)
  );
  // threshold decoding
  cmm_thresh_decode u_thr (
    .start_code_in(miss_mode_reg[cmm_pkg::CMM_MM_START_LO +: 2]),
    .stop_code_in(miss_mode_reg[cmm_pkg::CMM_MM_STOP_LO +: 2]),
    .start_count_out(start_cnt),
    .stop_count_out(stop_cnt)
  );
  //---------------------------------------------------------------------------
  // register write
  //---------------------------------------------------------------------------
  // cache mode keeps value on timeout reset
  assign cache_mode_next = wr_cache ? reg_wdata_in[3:0] : cache_mode_reg;
  // miss mode: status bits never stored, arbiter disable cleared by timeout
  wire [11:0] miss_wr = wr_miss ? (reg_wdata_in & cmm_pkg::CMM_MM_WMASK) : miss_mode_reg;
  wire [11:0] arb_clr = ~(12'h001 << cmm_pkg::CMM_MM_ARB_DIS);
  assign miss_mode_next = timeout_reset_in ? (miss_wr & arb_clr) : miss_wr;
  // read mux with live status
  wire [11:0] miss_view = miss_mode_reg |
                          ({11'h000, pend_sync[0]} << cmm_pkg::CMM_MM_RD_PEND) |
                          ({11'h000, pend_sync[1]} << cmm_pkg::CMM_MM_WB_PEND);
  assign rdata_next = !reg_rd_in ? 12'h000 :
                      sel_cache ? {8'h00, cache_mode_reg} :
                      sel_miss ? miss_view : 12'h000;
  // register update, chip reset clears both
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cache_mode_reg <= cmm_pkg::CMM_CM_RST;
      miss_mode_reg <= cmm_pkg::CMM_MM_RST;
      rdata_reg <= 12'h000;
    end else begin
      cache_mode_reg <= cache_mode_next;
      miss_mode_reg <= miss_mode_next;
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata_out = rdata_reg;
  //---------------------------------------------------------------------------
  // cache control
  //---------------------------------------------------------------------------
  // force hit overrides tag and disable; without force hit, disable forces miss
  wire hit_c = cctl.cache_force_hit | (cctl.cache_enable & cache_tag_match_in);
  wire wen_c = cctl.cache_enable & (cache_fill_in | (cache_store_in & hit_c));
  // inversion only on integer store hits, never fills
  wire inv_c = cctl.parity_corrupt_inject & cache_int_store_in & hit_c & ~cache_fill_in;
  wire par_c = cache_data_parity_in ^ inv_c;
  wire rpt_c = ~cctl.parity_report_disable & (cache_tag_perr_in | cache_data_perr_in);
  wire unused_ld = cache_load_in;
  assign cache_out_next = {4'h0, hit_c & (cache_load_in | cache_store_in | 1'b1), wen_c,
                           par_c, rpt_c};
  //---------------------------------------------------------------------------
  // miss file control
  //---------------------------------------------------------------------------
  wire ld_nm = load_issue_in & mctl.read_miss_merge_disable;
  wire st_nm = store_issue_in & mctl.store_buffer_merge_disable;
  wire io_nm = load_issue_in & mctl.io_load_merge_prevent &
               load_paddr_in[cmm_pkg::CMM_IO_ADDR_BIT];
  wire flush = mctl.store_buffer_flush_always & (wb_count_in != 3'h0);
  wire rd_ok = read_miss_req_in & ~mctl.miss_arbiter_disable;
  wire wb_ok = wb_req_in & ~mctl.miss_arbiter_disable;
  wire oth_ok = other_req_in;
  // age timer counts while buffer holds entries and timer enabled
  wire timer_hit = ~mctl.store_buffer_timer_disable & (wb_timer_reg == cmm_pkg::CMM_WB_TIMEOUT);
  assign wb_timer_next = (wb_count_in == 3'h0 || mctl.store_buffer_timer_disable) ? 9'h000 :
                         timer_hit ? 9'h000 : wb_timer_reg + 9'h001;
  // hysteresis between start and stop thresholds
  always_comb begin
    lp_state_next = lp_state_reg;
    case (lp_state_reg)
      cmm_pkg::CMM_LP_IDLE: begin
        if (wb_count_in >= start_cnt) begin
          lp_state_next = cmm_pkg::CMM_LP_ACTIVE;
        end
      end
      cmm_pkg::CMM_LP_ACTIVE: begin
        if (wb_count_in <= stop_cnt) begin
          lp_state_next = cmm_pkg::CMM_LP_IDLE;
        end
      end
      default: begin
        lp_state_next = cmm_pkg::CMM_LP_IDLE;
      end
    endcase
  end
  wire lp_req = (wb_count_in != 3'h0) &
                (load_locked_in | (lp_state_next == cmm_pkg::CMM_LP_ACTIVE) | timer_hit);
  assign miss_out_next = {ld_nm, st_nm, io_nm, flush, rd_ok, wb_ok, oth_ok, lp_req};
  // control state and registered outputs
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wb_timer_reg <= 9'h000;
      lp_state_reg <= cmm_pkg::CMM_LP_IDLE;
      cache_out_reg <= 8'h00;
      miss_out_reg <= 8'h00;
    end else begin
      wb_timer_reg <= wb_timer_next;
      lp_state_reg <= lp_state_next;
      cache_out_reg <= cache_out_next;
      miss_out_reg <= miss_out_next;
    end
  end
  assign cache_hit_out = cache_out_reg[3];
  assign cache_write_en_out = cache_out_reg[2];
  assign cache_data_parity_out = cache_out_reg[1];
  assign cache_perr_report_out = cache_out_reg[0];
  assign load_new_nomerge_out = miss_out_reg[7];
  assign store_new_nomerge_out = miss_out_reg[6];
  assign io_load_nomerge_out = miss_out_reg[5];
  assign wb_flush_out = miss_out_reg[4];
  assign read_miss_grant_ok_out = miss_out_reg[3];
  assign wb_grant_ok_out = miss_out_reg[2];
  assign other_grant_ok_out = miss_out_reg[1];
  assign wb_low_prio_req_out = miss_out_reg[0];
  //---------------------------------------------------------------------------
  // assertions
  //---------------------------------------------------------------------------
  sequence s_wr_cache;
    wr_cache && !timeout_reset_in;
  endsequence
  property p_cache_hold_timeout;
    @(posedge clk_in) disable iff (!reset_n_in)
    (timeout_reset_in && !wr_cache) |=> (cache_mode_reg == $past(cache_mode_reg));
  endproperty
  a_cache_hold_timeout: assert property (p_cache_hold_timeout) else $error("cache mode lost");
  property p_cache_write;
    @(posedge clk_in) disable iff (!reset_n_in)
    s_wr_cache |=> (cache_mode_reg == $past(reg_wdata_in[3:0]));
  endproperty
  a_cache_write: assert property (p_cache_write) else $error("cache mode not written");
  property p_force_hit;
    @(posedge clk_in) disable iff (!reset_n_in)
    cctl.cache_force_hit |=> cache_hit_out;
  endproperty
  a_force_hit: assert property (p_force_hit) else $error("force hit missed");
  property p_disable_miss;
    @(posedge clk_in) disable iff (!reset_n_in)
    (!cctl.cache_enable && !cctl.cache_force_hit) |=> (!cache_hit_out && !cache_write_en_out);
  endproperty
  a_disable_miss: assert property (p_disable_miss) else $error("disabled cache hit");
  property p_fill_parity;
    @(posedge clk_in) disable iff (!reset_n_in)
    cache_fill_in |=> (cache_data_parity_out == $past(cache_data_parity_in));
  endproperty
  a_fill_parity: assert property (p_fill_parity) else $error("fill parity altered");
  property p_perr_mask;
    @(posedge clk_in) disable iff (!reset_n_in)
    cctl.parity_report_disable |=> !cache_perr_report_out;
  endproperty
  a_perr_mask: assert property (p_perr_mask) else $error("parity reported");
  property p_timeout_arb;
    @(posedge clk_in) disable iff (!reset_n_in)
    timeout_reset_in |=> !miss_mode_reg[cmm_pkg::CMM_MM_ARB_DIS];
  endproperty
  a_timeout_arb: assert property (p_timeout_arb) else $error("arb disable kept");
  property p_arb_block;
    @(posedge clk_in) disable iff (!reset_n_in)
    mctl.miss_arbiter_disable |=> (!read_miss_grant_ok_out && !wb_grant_ok_out);
  endproperty
  a_arb_block: assert property (p_arb_block) else $error("request not blocked");
  property p_flush;
    @(posedge clk_in) disable iff (!reset_n_in)
    (mctl.store_buffer_flush_always && wb_count_in != 3'h0) |=> wb_flush_out;
  endproperty
  a_flush: assert property (p_flush) else $error("no flush");
  property p_status_ro;
    @(posedge clk_in) disable iff (!reset_n_in)
    1'b1 |-> (miss_mode_reg[7:6] == 2'h0);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status bits stored");
  property p_rd_pend;
    @(posedge clk_in) disable iff (!reset_n_in)
    (reg_rd_in && sel_miss) |=> (reg_rdata_out[cmm_pkg::CMM_MM_RD_PEND] == $past(pend_sync[0]));
  endproperty
  a_rd_pend: assert property (p_rd_pend) else $error("read pending wrong");
  // store buffer pending bit tracks the synchronised level
  property p_wb_pend;
    @(posedge clk_in) disable iff (!reset_n_in)
    (reg_rd_in && sel_miss) |=> (reg_rdata_out[cmm_pkg::CMM_MM_WB_PEND] == $past(pend_sync[1]));
  endproperty
  a_wb_pend: assert property (p_wb_pend) else $error("store pending wrong");
  // loads issued under read merge disable are flagged unmergeable
  property p_ld_nomerge;
    @(posedge clk_in) disable iff (!reset_n_in)
    (load_issue_in && mctl.read_miss_merge_disable) |=> load_new_nomerge_out;
  endproperty
  a_ld_nomerge: assert property (p_ld_nomerge) else $error("load not flagged");
endmodule // cmm_mode_ctl
`default_nettype wire

// [core/cmm_pkg.sv]
// package of constants and types for the cache and miss file mode control block
//-----------------------------------------------------------------------------
// Overview of operation
// - cache mode clears on chip reset only
// - force hit makes every reference hit
// - inject inverts store-hit data parity only
// - report disable masks cache parity errors
// - miss mode clears on chip reset, bit5 timeout
// - read merge disable allocates unmergeable entries
// - flush always flushes buffer with entries
// - store merge disable allocates unmergeable entries
// - io prevent blocks io load merges
// - timer disable: low prio on lock/threshold
// - arbiter disable blocks read and store requests
// - bit6 shows read miss outstanding
// - bit7 shows store buffer outstanding
// - start threshold decodes 3,4,5,2 entries
// - stop threshold decodes 0,1,2,3 entries
//-----------------------------------------------------------------------------
`default_nettype none
package cmm_pkg;
  // register indices (printed offsets)
  localparam logic [9:0] CMM_IDX_CACHE_MODE = 10'h216;
  localparam logic [9:0] CMM_IDX_MISS_MODE = 10'h217;
  // cache mode field positions
  localparam int CMM_CM_ENABLE = 0;
  localparam int CMM_CM_FORCE_HIT = 1;
  localparam int CMM_CM_PAR_INJECT = 2;
  localparam int CMM_CM_PAR_RPT_DIS = 3;
  // miss mode field positions
  localparam int CMM_MM_RD_NOMERGE = 0;
  localparam int CMM_MM_FLUSH_ALWAYS = 1;
  localparam int CMM_MM_STORE_BUFFER_MERGE_DISABLE = 2;
  localparam int CMM_MM_IO_NOMERGE = 3;
  localparam int CMM_MM_TIMER_DIS = 4;
  localparam int CMM_MM_ARB_DIS = 5;
  localparam int CMM_MM_RD_PEND = 6;
  localparam int CMM_MM_WB_PEND = 7;
  localparam int CMM_MM_START_LO = 8;
  localparam int CMM_MM_STOP_LO = 10;
  // widths and reset values
  localparam int CMM_CM_W = 4;
  localparam int CMM_MM_W = 12;
  localparam logic [3:0] CMM_CM_RST = 4'h0;
  localparam logic [11:0] CMM_MM_RST = 12'h000;
  localparam logic [11:0] CMM_MM_WMASK = 12'hF3F;
  // physical address io space bit
  localparam int CMM_IO_ADDR_BIT = 39;
  // store buffer timer length and count width
  localparam logic [8:0] CMM_WB_TIMEOUT = 9'h100;
  localparam int CMM_CNT_W = 3;
  // threshold code table
  localparam logic [2:0] CMM_START_00 = 3'h3;
  localparam logic [2:0] CMM_START_01 = 3'h4;
  localparam logic [2:0] CMM_START_10 = 3'h5;
  localparam logic [2:0] CMM_START_11 = 3'h2;
  localparam logic [2:0] CMM_STOP_00 = 3'h0;
  localparam logic [2:0] CMM_STOP_01 = 3'h1;
  localparam logic [2:0] CMM_STOP_10 = 3'h2;
  localparam logic [2:0] CMM_STOP_11 = 3'h3;
  // cache control group
  typedef struct packed {
    logic cache_enable;
    logic cache_force_hit;
    logic parity_corrupt_inject;
    logic parity_report_disable;
  } cmm_cache_ctl_t;
  // miss file control group
  typedef struct packed {
    logic read_miss_merge_disable;
    logic store_buffer_flush_always;
    logic store_buffer_merge_disable;
    logic io_load_merge_prevent;
    logic store_buffer_timer_disable;
    logic miss_arbiter_disable;
  } cmm_miss_ctl_t;
  // low priority arbitration state
  typedef enum logic [0:0] {CMM_LP_IDLE, CMM_LP_ACTIVE} cmm_lp_state_t;
endpackage
`default_nettype wire

// [core/cmm_thresh_decode.sv]
// threshold code decoder for store buffer low priority arbitration
`default_nettype none
module cmm_thresh_decode (
  // codes
  input wire logic [1:0] start_code_in,
  input wire logic [1:0] stop_code_in,
  // decoded entry counts
  output logic [2:0] start_count_out,
  output logic [2:0] stop_count_out
);
  // start code lookup
  assign start_count_out = (start_code_in == 2'h0) ? cmm_pkg::CMM_START_00 :
                           (start_code_in == 2'h1) ? cmm_pkg::CMM_START_01 :
                           (start_code_in == 2'h2) ? cmm_pkg::CMM_START_10 :
                           cmm_pkg::CMM_START_11;
  // stop code lookup
  assign stop_count_out = (stop_code_in == 2'h0) ? cmm_pkg::CMM_STOP_00 :
                          (stop_code_in == 2'h1) ? cmm_pkg::CMM_STOP_01 :
                          (stop_code_in == 2'h2) ? cmm_pkg::CMM_STOP_10 :
                          cmm_pkg::CMM_STOP_11;
endmodule // cmm_thresh_decode
`default_nettype wire

// [core/cmm_status_sync.sv]
// two flop synchroniser for the outstanding request levels
`default_nettype none
module cmm_status_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // raw levels
  input wire logic [1:0] level_in,
  // synchronised levels
  output logic [1:0] level_out
);
  logic [1:0] stage1_reg; // first stage, read only by the second
  logic [1:0] stage2_reg; // second stage
  // two flops per level
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1_reg <= 2'h0;
      stage2_reg <= 2'h0;
    end else begin
      stage1_reg <= level_in;
      stage2_reg <= stage1_reg;
    end
  end
  assign level_out = stage2_reg;
endmodule // cmm_status_sync
`default_nettype wire

// [sim/tb.sv]
// self-checking testbench for the cache and miss file mode control block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------
  typedef struct {int due; int sel; logic [11:0] exp;} cmm_note_t;
  logic clk_in = 1'b0; // 40 MHz core clock
  logic reset_n_in, timeout_reset_in, reg_wr_in, reg_rd_in;
  logic [9:0] reg_addr_in;
  logic [11:0] reg_wdata_in, reg_rdata_out;
  logic c_tm, c_ld, c_st, c_fill, c_ist, c_par, c_tpe, c_dpe; // cache side stimulus
  logic hit, wen, par_o, perr; // cache side results
  logic l_iss, s_iss, locked, rm_req, wb_req, oth_req, rd_out, wb_out; // miss side stimulus
  logic [39:0] paddr;
  logic [2:0] wb_cnt;
  logic lnm, snm, ionm, flush, rd_ok, wb_ok, oth_ok, lowp; // miss side results
  cmm_note_t q[$]; // expected results, oldest first
  int cyc = 0;
  int err_total = 0;
  int checked = 0;
  logic [31:0] seed = 32'h09EE36A1;
  // clock, inverted every half period
  always #12.5 clk_in = ~clk_in;
  // ----------------------------------------------------------------
  // device under test
  // ----------------------------------------------------------------
  cmm_mode_ctl i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .timeout_reset_in(timeout_reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .cache_tag_match_in(c_tm), .cache_load_in(c_ld),
    .cache_store_in(c_st), .cache_fill_in(c_fill), .cache_int_store_in(c_ist),
    .cache_data_parity_in(c_par), .cache_tag_perr_in(c_tpe), .cache_data_perr_in(c_dpe),
    .cache_hit_out(hit), .cache_write_en_out(wen), .cache_data_parity_out(par_o),
    .cache_perr_report_out(perr), .load_issue_in(l_iss), .store_issue_in(s_iss),
    .load_paddr_in(paddr), .load_locked_in(locked), .wb_count_in(wb_cnt),
    .read_miss_req_in(rm_req), .wb_req_in(wb_req), .other_req_in(oth_req),
    .read_outstanding_in(rd_out), .wb_outstanding_in(wb_out),
    .load_new_nomerge_out(lnm), .store_new_nomerge_out(snm), .io_load_nomerge_out(ionm),
    .wb_flush_out(flush), .read_miss_grant_ok_out(rd_ok), .wb_grant_ok_out(wb_ok),
    .other_grant_ok_out(oth_ok), .wb_low_prio_req_out(lowp));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // pseudo random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // picks the output group that a note refers to
  function automatic logic [11:0] seen(input int sel);
    case (sel)
      0: return reg_rdata_out;
      1: return {8'h00, hit, wen, par_o, perr};
      2: return {5'h00, lnm, snm, ionm, flush, rd_ok, wb_ok, oth_ok};
      default: return {11'h000, lowp};
    endcase
  endfunction
  // one comparison, counted
  task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // result due one edge after the current one
  task automatic note(input int sel, input logic [11:0] e);
    q.push_back('{cyc + 1, sel, e});
  endtask
  // one bus cycle; entered and left just after a rising edge
  task automatic bus(input logic w, input logic r, input logic [9:0] a, input logic [11:0] d);
    reg_wr_in <= w;
    reg_rd_in <= r;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [9:0] a, input logic [11:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [9:0] a, input logic [11:0] e);
    note(0, e);
    bus(1'b0, 1'b1, a, 12'h000);
  endtask
  task automatic idle;
    bus(1'b0, 1'b0, 10'h000, 12'h000);
  endtask
  // steady inputs, then one check of a level
  task automatic hold(input int sel, input logic [11:0] e);
    repeat (4) @(posedge clk_in);
    note(sel, e);
    @(posedge clk_in);
  endtask
  // verdict and end of run
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // monitor: takes due notes off the queue at the falling edge
  // ----------------------------------------------------------------
  always @(negedge clk_in) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      cmp($sformatf("group%0d", q[0].sel), q[0].exp, seen(q[0].sel));
      void'(q.pop_front());
    end
    cyc = cyc + 1;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    close_out();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [3:0] m;
    logic [5:0] mm;
    logic [7:0] i;
    logic h;
    int n;
    logic [2:0] st_tab [4];
    logic [2:0] sp_tab [4];
    st_tab = '{3'h3, 3'h4, 3'h5, 3'h2};
    sp_tab = '{3'h0, 3'h1, 3'h2, 3'h3};
    {reset_n_in, timeout_reset_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
    {c_tm, c_ld, c_st, c_fill, c_ist, c_par, c_tpe, c_dpe} = '0;
    {l_iss, s_iss, locked, rm_req, wb_req, oth_req, rd_out, wb_out, paddr, wb_cnt} = '0;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    // reset values, access kinds, unmapped places
    rd(cmm_pkg::CMM_IDX_CACHE_MODE, 12'h000);
    rd(cmm_pkg::CMM_IDX_MISS_MODE, 12'h000);
    wr(cmm_pkg::CMM_IDX_CACHE_MODE, 12'hFFF);
    rd(cmm_pkg::CMM_IDX_CACHE_MODE, 12'h00F);
    wr(cmm_pkg::CMM_IDX_MISS_MODE, 12'hFFF);
    rd(cmm_pkg::CMM_IDX_MISS_MODE, 12'hF3F);
    wr(10'h218, 12'h000);
    rd(10'h215, 12'h000);
    rd(cmm_pkg::CMM_IDX_CACHE_MODE, 12'h00F);
    // timeout reset clears only the arbiter disable
    timeout_reset_in <= 1'b1;
    idle();
    timeout_reset_in <= 1'b0;
    rd(cmm_pkg::CMM_IDX_MISS_MODE, 12'hF1F);
    rd(cmm_pkg::CMM_IDX_CACHE_MODE, 12'h00F);
    // live outstanding status
    rd_out <= 1'b1;
    idle();
    repeat (5) @(posedge clk_in);
    rd(cmm_pkg::CMM_IDX_MISS_MODE, 12'hF5F);
    rd_out <= 1'b0;
    wb_out <= 1'b1;
    idle();
    repeat (5) @(posedge clk_in);
    rd(cmm_pkg::CMM_IDX_MISS_MODE, 12'hF9F);
    wr(cmm_pkg::CMM_IDX_MISS_MODE, 12'h0C0);
    rd(cmm_pkg::CMM_IDX_MISS_MODE, 12'h080);
    wb_out <= 1'b0;
    // cache controls under random modes, one write per cycle
    repeat (40) begin
      seed = lfsr(seed);
      m = seed[3:0];
      i = seed[11:4];
      if (m[2]) i[4] = i[4] | i[2];
      wr(cmm_pkg::CMM_IDX_CACHE_MODE, {8'h00, m});
      {c_dpe, c_tpe, c_par, c_ist, c_fill, c_st, c_ld, c_tm} <= i;
      h = m[1] | (m[0] & i[0]);
      note(1, {8'h00, h, m[0] & (i[3] | (i[2] & h)), i[5] ^ (m[2] & i[4] & h & ~i[3]),
        ~m[3] & (i[6] | i[7])});
    end
    // miss file controls under random modes
    repeat (40) begin
      seed = lfsr(seed);
      mm = seed[5:0];
      i = seed[13:6];
      wr(cmm_pkg::CMM_IDX_MISS_MODE, {6'h00, mm});
      {oth_req, wb_req, rm_req, s_iss, l_iss} <= i[4:0];
      paddr <= {seed[14], 7'h00, seed};
      wb_cnt <= seed[17:15];
      note(2, {5'h00, i[0] & mm[0], i[1] & mm[2], i[0] & mm[3] & seed[14],
        mm[1] & (seed[17:15] != 3'h0), i[2] & ~mm[5], i[3] & ~mm[5], i[4]});
    end
    idle();
    // low priority start and stop thresholds, timer off
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 4; c++) begin
        if (st_tab[s] > sp_tab[c]) begin
          wr(cmm_pkg::CMM_IDX_MISS_MODE, {c[1:0], s[1:0], 8'h10});
          idle();
          wb_cnt <= 3'h0;
          hold(3, 12'h000);
          wb_cnt <= st_tab[s] - 3'h1;
          hold(3, 12'h000);
          wb_cnt <= st_tab[s];
          hold(3, 12'h001);
          wb_cnt <= sp_tab[c] + 3'h1;
          hold(3, 12'h001);
          wb_cnt <= sp_tab[c];
          hold(3, 12'h000);
        end
      end
    end
    // locked load, then a long wait with the timer off
    wr(cmm_pkg::CMM_IDX_MISS_MODE, 12'h010);
    idle();
    wb_cnt <= 3'h1;
    locked <= 1'b1;
    hold(3, 12'h001);
    locked <= 1'b0;
    repeat (300) @(posedge clk_in);
    hold(3, 12'h000);
    // timer on: request comes after about 256 cycles
    wr(cmm_pkg::CMM_IDX_MISS_MODE, 12'h000);
    idle();
    n = 0;
    // sampled at the falling edge, where the registered output has settled
    while (lowp !== 1'b1 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    @(posedge clk_in);
    cmp("timer age", 12'h001, {11'h000, n >= 250 && n <= 262});
    // chip reset in mid-run
    wr(cmm_pkg::CMM_IDX_CACHE_MODE, 12'h001);
    wr(cmm_pkg::CMM_IDX_MISS_MODE, 12'h03F);
    idle();
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    rd(cmm_pkg::CMM_IDX_CACHE_MODE, 12'h000);
    rd(cmm_pkg::CMM_IDX_MISS_MODE, 12'h000);
    idle();
    repeat (3) @(posedge clk_in);
    close_out();
  end
endmodule // tb
`default_nettype wire
